// ### rtl/dcs_pkg.sv
package dcs_pkg;
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;
    // channel geometry
    localparam int NUM_CH = 8;
    localparam int CNT_W = 16;
    localparam int PRESC_W = 16;
    // register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_START = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CONNECT = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_PRESC = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_CNT_BASE = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 8'h04;
    // reset values
    localparam logic [NUM_CH-1:0] START_RST = 8'h00;
    localparam logic [NUM_CH-1:0] CONNECT_RST = 8'h00;
    localparam logic [NUM_CH-1:0] MODE_RST = 8'h00;
    localparam logic [PRESC_W-1:0] PRESC_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### rtl/dcs_down_counter.sv
`timescale 1ns/10ps
module dcs_down_counter #(
    parameter int W = 16
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic tick,
    input wire logic run,
    output logic [W-1:0] count_q,
    output logic uflow
);
    import dcs_pkg::*;

    logic [W-1:0] count_d;
    logic at_zero;

    // tick at zero while running is the underflow; value holds at zero
    always_comb begin
        at_zero = (count_q == '0);
        uflow = tick & run & at_zero;
        count_d = count_q;
        if (load) begin
            count_d = load_val;
        end else if (tick && run && !at_zero) begin
            count_d = count_q - W'(1);
        end
    end

    // counter register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            count_q <= W'(CNT_RST);
        end else begin
            count_q <= count_d;
        end
    end
endmodule

// ### rtl/dcs_axil_port.sv
`timescale 1ns/10ps
module dcs_axil_port (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [dcs_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [dcs_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [dcs_pkg::STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [dcs_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [dcs_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_fire,
    output logic [dcs_pkg::ADDR_W-1:0] wr_addr,
    output logic [dcs_pkg::DATA_W-1:0] wr_data,
    output logic [dcs_pkg::STRB_W-1:0] wr_strb,
    input wire logic wr_ok,
    output logic rd_take,
    input wire logic [dcs_pkg::DATA_W-1:0] rd_data,
    input wire logic rd_ok
);
    import dcs_pkg::*;

    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
    logic [1:0] bresp_d, rresp_d;
    logic [ADDR_W-1:0] addr_d;
    logic [DATA_W-1:0] data_d, rdata_d;
    logic [STRB_W-1:0] strb_d;

    // address and data taken in either order, response after both
    always_comb begin
        wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
        rd_take = s_axi_arvalid & s_axi_arready;
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        awready_d = s_axi_awready;
        wready_d = s_axi_wready;
        bvalid_d = s_axi_bvalid;
        bresp_d = s_axi_bresp;
        addr_d = wr_addr;
        data_d = wr_data;
        strb_d = wr_strb;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_d = 1'b1;
            awready_d = 1'b0;
            addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_d = 1'b1;
            wready_d = 1'b0;
            data_d = s_axi_wdata;
            strb_d = s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_d = 1'b0;
            awready_d = 1'b1;
            wready_d = 1'b1;
        end
    end

    // read answered one edge after the address is taken
    always_comb begin
        arready_d = s_axi_arready;
        rvalid_d = s_axi_rvalid;
        rdata_d = s_axi_rdata;
        rresp_d = s_axi_rresp;
        if (rd_take) begin
            arready_d = 1'b0;
            rvalid_d = 1'b1;
            rdata_d = rd_data;
            rresp_d = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            rvalid_d = 1'b0;
            arready_d = 1'b1;
        end
    end

    // channel registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= '0;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            s_axi_awready <= awready_d;
            s_axi_wready <= wready_d;
            s_axi_bvalid <= bvalid_d;
            s_axi_bresp <= bresp_d;
            wr_addr <= addr_d;
            wr_data <= data_d;
            wr_strb <= strb_d;
            s_axi_arready <= arready_d;
            s_axi_rvalid <= rvalid_d;
            s_axi_rdata <= rdata_d;
            s_axi_rresp <= rresp_d;
        end
    end
endmodule

// ### rtl/dcs_oneshot_start.sv
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module dcs_oneshot_start (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [dcs_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [dcs_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [dcs_pkg::STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [dcs_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [dcs_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cmp_output_compare_ch1_match,
    input wire logic [dcs_pkg::NUM_CH-1:0] cmp_general_match,
    output logic [dcs_pkg::NUM_CH-1:0] start_flag,
    output logic [dcs_pkg::NUM_CH-1:0] count_underflow
);
    import dcs_pkg::*;

    // byte address of down-counter n
    function automatic logic [ADDR_W-1:0] cnt_addr(input int n);
        cnt_addr = ADDR_CNT_BASE + ADDR_W'(n) * ADDR_STEP;
    endfunction

    // mapped-address check shared by read and write
    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        addr_ok = (a == ADDR_START) || (a == ADDR_CONNECT) ||
                  (a == ADDR_MODE) || (a == ADDR_PRESC);
        for (int n = 0; n < NUM_CH; n++) begin
            if (a == cnt_addr(n)) begin
                addr_ok = 1'b1;
            end
        end
    endfunction

    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [DATA_W-1:0] d,
                                            input logic [STRB_W-1:0] s);
        merge16 = old;
        if (s[0]) begin
            merge16[7:0] = d[7:0];
        end
        if (s[1]) begin
            merge16[15:8] = d[15:8];
        end
    endfunction

    logic wr_fire, wr_ok, rd_take, rd_ok;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data, rd_data;
    logic [STRB_W-1:0] wr_strb;

    dcs_axil_port u_port (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_fire(wr_fire),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_take(rd_take),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    logic [NUM_CH-1:0] start_q, start_d;
    logic [NUM_CH-1:0] connect_q, connect_d;
    logic [NUM_CH-1:0] mode_q, mode_d;
    logic [PRESC_W-1:0] presc_q, presc_d, div_q, div_d;
    logic tick_q, tick_d;
    logic [NUM_CH-1:0] uflow_q;
    logic [NUM_CH-1:0] uflow_w, zero_w, load_w;
    logic [NUM_CH-1:0] match_w, sw_set_w, hw_set_w, clr_w;
    logic [CNT_W-1:0] count_w [NUM_CH];

    // one counter per letter a to h
    for (genvar g = 0; g < NUM_CH; g++) begin : g_cnt
        assign load_w[g] = wr_fire && (wr_addr == cnt_addr(g)) &&
                           (wr_strb[1:0] != 2'h0);
        assign zero_w[g] = (count_w[g] == '0);
        dcs_down_counter #(
            .W(CNT_W)
        ) u_cnt (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .load(load_w[g]),
            .load_val(merge16(count_w[g], wr_data, wr_strb)),
            .tick(tick_q),
            .run(start_q[g]),
            .count_q(count_w[g]),
            .uflow(uflow_w[g])
        );
    end

    // count prescaler, one-cycle tick every presc+1 clocks
    always_comb begin
        tick_d = (div_q == presc_q);
        div_d = tick_d ? '0 : div_q + PRESC_W'(1);
    end

    // start flag set and clear; a set wins over a clear in the same cycle
    always_comb begin
        match_w = {NUM_CH{cmp_output_compare_ch1_match}} | cmp_general_match;
        sw_set_w = '0;
        if (wr_fire && wr_addr == ADDR_START && wr_strb[0]) begin
            sw_set_w = wr_data[NUM_CH-1:0] & ~zero_w;
        end
        hw_set_w = mode_q & connect_q & match_w & ~zero_w;
        clr_w = uflow_w | match_w;
        start_d = (start_q & ~clr_w) | sw_set_w | hw_set_w;
    end

    // software-written control registers
    always_comb begin
        connect_d = connect_q;
        mode_d = mode_q;
        presc_d = presc_q;
        if (wr_fire && wr_strb[0]) begin
            if (wr_addr == ADDR_CONNECT) begin
                connect_d = wr_data[NUM_CH-1:0];
            end
            if (wr_addr == ADDR_MODE) begin
                mode_d = wr_data[NUM_CH-1:0];
            end
        end
        if (wr_fire && wr_addr == ADDR_PRESC) begin
            presc_d = merge16(presc_q, wr_data, wr_strb);
        end
    end

    // write decode answer and read mux
    always_comb begin
        wr_ok = addr_ok(wr_addr);
        rd_ok = addr_ok(s_axi_araddr);
        rd_data = '0;
        unique case (s_axi_araddr)
            ADDR_START: rd_data[NUM_CH-1:0] = start_q;
            ADDR_CONNECT: rd_data[NUM_CH-1:0] = connect_q;
            ADDR_MODE: rd_data[NUM_CH-1:0] = mode_q;
            ADDR_PRESC: rd_data[PRESC_W-1:0] = presc_q;
            default: begin
                for (int n = 0; n < NUM_CH; n++) begin
                    if (s_axi_araddr == cnt_addr(n)) begin
                        rd_data[CNT_W-1:0] = count_w[n];
                    end
                end
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            start_q <= START_RST;
            connect_q <= CONNECT_RST;
            mode_q <= MODE_RST;
            presc_q <= PRESC_RST;
            div_q <= '0;
            tick_q <= 1'b0;
            uflow_q <= '0;
        end else begin
            start_q <= start_d;
            connect_q <= connect_d;
            mode_q <= mode_d;
            presc_q <= presc_d;
            div_q <= div_d;
            tick_q <= tick_d;
            uflow_q <= uflow_w;
        end
    end

    assign start_flag = start_q;
    assign count_underflow = uflow_q;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // software start write on the register bus
    sequence s_sw_start;
        wr_fire && wr_addr == ADDR_START && wr_strb[0];
    endsequence

    // a compare match reaching an armed, connected offset channel
    sequence s_hw_start;
        (mode_q & connect_q & match_w & ~zero_w) != '0;
    endsequence

    a_reset_stopped: assert property (
        $rose(rst_n) |-> start_q == '0
    ) else $error("start flags not cleared by reset");

    a_run_decrements: assert property (
        (tick_q && start_q[0] && !zero_w[0] && !load_w[0]) |=>
            count_w[0] == $past(count_w[0]) - CNT_W'(1)
    ) else $error("running counter a did not decrement");

    a_uflow_clears: assert property (
        (uflow_w & ~sw_set_w & ~hw_set_w) != '0 |=>
            (start_q & $past(uflow_w & ~sw_set_w & ~hw_set_w)) == '0
    ) else $error("underflow did not clear start flag");

    a_match_clears: assert property (
        ((match_w & ~hw_set_w & ~sw_set_w) != '0) |=>
            (start_q & $past(match_w & ~hw_set_w & ~sw_set_w)) == '0
    ) else $error("compare match did not clear start flag");

    a_zero_no_start: assert property (
        1'b1 |=> (start_q & ~$past(start_q) & $past(zero_w)) == '0
    ) else $error("start flag rose with counter at zero");

    a_offset_sets: assert property (
        s_hw_start |=>
            (($past(mode_q & connect_q & match_w & ~zero_w) & ~start_q)
             == '0)
    ) else $error("offset compare match did not set start flag");

    a_sw_sets: assert property (
        s_sw_start ##0 ((wr_data[NUM_CH-1:0] & ~zero_w) != '0) |=>
            (($past(wr_data[NUM_CH-1:0] & ~zero_w) & ~start_q) == '0)
    ) else $error("software write of one did not set start flag");

    a_unconnected_ignored: assert property (
        1'b1 |=> (start_q & ~$past(start_q) & ~$past(sw_set_w) &
                  ~($past(mode_q) & $past(connect_q))) == '0
    ) else $error("start flag set by an unconnected trigger");

    a_write_answer: assert property (
        s_sw_start |=> s_axi_bvalid ##0 s_axi_bresp == RESP_OKAY
    ) else $error("start write not answered next cycle");

    // read address taken by the register bus
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    // read data stands at the next edge
    a_read_answer: assert property (
        s_rd_taken |=> s_axi_rvalid && !s_axi_arready
    ) else $error("read not answered next cycle");

    // unmapped read answers an error with zero data
    a_read_refused: assert property (
        s_rd_taken ##0 !rd_ok |=>
            s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0
    ) else $error("unmapped read not refused");

    // an underflow pulse finds its flag already cleared
    a_uflow_stops: assert property (
        (count_underflow & start_flag) == '0
    ) else $error("start flag still set beside its underflow pulse");

    // plain one-shot letters start only from software
    a_plain_sw_only: assert property (
        1'b1 |=> (start_q & ~$past(start_q) & ~$past(sw_set_w) &
                  ~$past(mode_q)) == '0
    ) else $error("plain one-shot flag set by hardware");

    // a written zero bit never starts its letter
    a_sw_zero_ignored: assert property (
        s_sw_start ##0 (hw_set_w == '0) |=>
            (start_q & ~$past(start_q) & ~$past(wr_data[NUM_CH-1:0])) == '0
    ) else $error("software write of zero started a counter");

    // a prescaler above zero spaces the ticks apart
    a_tick_spacing: assert property (
        tick_q && presc_q != '0 |=> !tick_q
    ) else $error("prescaled tick repeated on consecutive cycles");

    // a stopped counter keeps its value unless written
    a_stopped_holds: assert property (
        !start_q[0] && !load_w[0] |=> $stable(count_w[0])
    ) else $error("stopped counter a changed");
endmodule

// ### verif/dcs_cmp_model.sv
`timescale 1ns/10ps
module dcs_cmp_model (
    input wire logic clk_sys,
    output logic cmp_output_compare_ch1_match,
    output logic [dcs_pkg::NUM_CH-1:0] cmp_general_match
);
    import dcs_pkg::*;
    // quiet compare outputs from time zero
    initial begin
        cmp_output_compare_ch1_match = 1'b0;
        cmp_general_match = '0;
    end
    // one-cycle compare match, launched just after an edge
    task automatic pulse(input logic ocr, input logic [NUM_CH-1:0] gen);
        @(posedge clk_sys);
        cmp_output_compare_ch1_match <= ocr;
        cmp_general_match <= gen;
        @(posedge clk_sys);
        cmp_output_compare_ch1_match <= 1'b0;
        cmp_general_match <= '0;
    endtask
endmodule

// ### verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import dcs_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = 8'h00;
    logic [ADDR_W-1:0] s_axi_araddr = 8'h00;
    logic [DATA_W-1:0] s_axi_wdata = 32'h0;
    logic [STRB_W-1:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, cmp_output_compare_ch1_match;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [DATA_W-1:0] s_axi_rdata;
    logic [NUM_CH-1:0] cmp_general_match, start_flag, count_underflow;
    int errors = 0;
    int comparisons = 0;
    int cyc = 0;
    int run_cnt [NUM_CH] = '{default: 0};
    int uf_cnt [NUM_CH] = '{default: 0};

    always #4 clk_sys = ~clk_sys;

    dcs_oneshot_start u_dut (
        .clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .cmp_output_compare_ch1_match, .cmp_general_match,
        .start_flag, .count_underflow
    );

    dcs_cmp_model u_cmp (.clk_sys, .cmp_output_compare_ch1_match, .cmp_general_match);

    task automatic results;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // running cycles and underflow pulses per letter, and one hang limit for the whole run
    always @(posedge clk_sys) begin
        cyc++;
        for (int i = 0; i < NUM_CH; i++) begin
            if (start_flag[i] === 1'b1)
                run_cnt[i]++;
            if (count_underflow[i] === 1'b1)
                uf_cnt[i]++;
        end
        if (cyc == 5000) begin
            errors++;
            results();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %0h expected %0h",
                     $time, seen, exp);
        end
    endtask

    // bus write: each channel held until its own ready
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic ap, wp, bp;
        ap = 1'b1;
        wp = 1'b1;
        bp = 1'b0;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!bp) begin
            @(posedge clk_sys);
            if (!ap && !wp && s_axi_bvalid === 1'b1) begin
                bp = 1'b1;
                chk(32'(s_axi_bresp), 32'(er));
            end
            if (ap && s_axi_awready === 1'b1) begin
                ap = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (wp && s_axi_wready === 1'b1) begin
                wp = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b0;
    endtask

    // bus read with data and response compared
    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] er);
        logic ap;
        ap = 1'b1;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (!ap && s_axi_rvalid === 1'b1)
                break;
            if (ap && s_axi_arready === 1'b1) begin
                ap = 1'b0;
                s_axi_arvalid <= 1'b0;
            end
        end
        chk(s_axi_rdata, e);
        chk(32'(s_axi_rresp), 32'(er));
        s_axi_rready <= 1'b0;
    endtask

    task automatic flg(input logic [7:0] exp);
        #1;
        chk(32'(start_flag), 32'(exp));
    endtask

    task automatic hit(input logic ocr, input logic [7:0] gen,
                       input logic [7:0] exp);
        u_cmp.pulse(ocr, gen);
        flg(exp);
    endtask

    task automatic t_reset;
        chk(32'(start_flag), 32'(START_RST));
        chk(32'(count_underflow), 32'h0);
        for (int a = 0; a < 12; a++) begin
            rdc(8'(4 * a), 32'h0, RESP_OKAY);
        end
        rdc(8'h30, 32'h0, RESP_SLVERR);
    endtask

    // start with every counter at zero is refused
    task automatic t_zero_start;
        wr(ADDR_START, 32'h0000_00FF, RESP_OKAY);
        flg(8'h00);
        wr(8'h40, 32'h0000_00FF, RESP_SLVERR);
        flg(8'h00);
    endtask

    // each letter runs count+1 ticks, then underflow stops it
    task automatic t_count;
        int r0 [NUM_CH];
        int u0 [NUM_CH];
        for (int i = 0; i < NUM_CH; i++) begin
            wr(ADDR_CNT_BASE + 8'(4 * i), 32'(i + 1), RESP_OKAY);
        end
        r0 = run_cnt;
        u0 = uf_cnt;
        wr(ADDR_START, 32'h0000_00FF, RESP_OKAY);
        repeat (20) @(posedge clk_sys);
        for (int i = 0; i < NUM_CH; i++) begin
            chk(32'(run_cnt[i] - r0[i]), 32'(i + 2));
            chk(32'(uf_cnt[i] - u0[i]), 32'h1);
            rdc(ADDR_CNT_BASE + 8'(4 * i), 32'h0, RESP_OKAY);
        end
        flg(8'h00);
    endtask

    // plain mode: software start, matches only clear
    task automatic t_clear;
        wr(8'h14, 32'h0000_00C8, RESP_OKAY);
        wr(8'h1C, 32'h0000_00C8, RESP_OKAY);
        wr(ADDR_START, 32'h0000_000A, RESP_OKAY);
        flg(8'h0A);
        wr(ADDR_START, 32'h0, RESP_OKAY);
        flg(8'h0A);
        hit(1'b0, 8'h02, 8'h08);
        wr(ADDR_CONNECT, 32'h0000_00FF, RESP_OKAY);
        hit(1'b1, 8'h00, 8'h00);
    endtask

    // offset mode: connected matches and software both start
    task automatic t_offset;
        int u6;
        wr(ADDR_MODE, 32'h0000_00FF, RESP_OKAY);
        wr(ADDR_CONNECT, 32'h0000_000F, RESP_OKAY);
        rdc(ADDR_MODE, 32'h0000_00FF, RESP_OKAY);
        rdc(ADDR_CONNECT, 32'h0000_000F, RESP_OKAY);
        for (int i = 0; i < NUM_CH; i++) begin
            wr(ADDR_CNT_BASE + 8'(4 * i), 32'h0000_00C8, RESP_OKAY);
        end
        hit(1'b0, 8'h05, 8'h05);
        hit(1'b1, 8'h00, 8'h0F);
        wr(ADDR_START, 32'h0000_00F0, RESP_OKAY);
        flg(8'hFF);
        hit(1'b0, 8'h30, 8'hCF);
        wr(8'h18, 32'h0, RESP_OKAY);
        hit(1'b0, 8'h04, 8'hCB);
        wr(ADDR_PRESC, 32'h0000_0003, RESP_OKAY);
        rdc(ADDR_PRESC, 32'h0000_0003, RESP_OKAY);
        // letter g reloaded with 2 needs three ticks, one every four clocks
        u6 = uf_cnt[6];
        wr(ADDR_CNT_BASE + 8'h18, 32'h0000_0002, RESP_OKAY);
        repeat (4) @(posedge clk_sys);
        flg(8'hCB);
        repeat (8) @(posedge clk_sys);
        flg(8'h8B);
        chk(32'(uf_cnt[6] - u6), 32'h1);
    endtask

    // reset for three edges, then the scenarios in turn
    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_zero_start();
        t_count();
        t_clear();
        t_offset();
        results();
    end
endmodule
